//--- src/pmx_defines.vh
`ifndef PMX_DEFINES_VH
`define PMX_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define PMX_OFS_PORT 8'h00
`define PMX_OFS_TMR0 8'h04
`define PMX_OFS_TMR1 8'h08
`define PMX_OFS_ADC 8'h0C
`define PMX_OFS_INTEN 8'h10
`define PMX_OFS_STATUS 8'h14

// ****************************************
// port register fields
// ****************************************
`define PMX_PORT_DIR_LO 0
`define PMX_PORT_DIR_HI 2
`define PMX_PORT_OUT_LO 3
`define PMX_PORT_OUT_HI 5

// ****************************************
// timer configuration fields (both timers; SOE is used by timer0 only)
// ****************************************
`define PMX_T_POE 0
`define PMX_T_SOE 1
`define PMX_T_CTS 2
`define PMX_T_CCF_LO 3
`define PMX_T_CCF_HI 4
`define PMX_T_GATE 5
`define PMX_T_CPRL 6
`define PMX_CCF_NONE 2'h0
`define PMX_CCF_CAPREL 2'h3

// ****************************************
// adc configuration fields and codes
// ****************************************
`define PMX_ADC_SRC_LO 0
`define PMX_ADC_SRC_HI 2
`define PMX_ADC_DUAL 3
`define PMX_ADC_EDGE 4
`define PMX_SRC_PIN 3'h4
`define PMX_SRC_PIN_INV 3'h5

// ****************************************
// interrupt enable fields
// ****************************************
`define PMX_IE_EX3 0
`define PMX_IE_EX4 1
`define PMX_IE_EX5 2

// ****************************************
// reset values and bus responses
// ****************************************
`define PMX_RST_PORT 6'h00
`define PMX_RST_TMR 7'h00
`define PMX_RST_ADC 5'h00
`define PMX_RST_INTEN 3'h0
`define PMX_RST_PIN_IDLE 1'h1
`define PMX_RESP_OKAY 2'h0
`define PMX_RESP_SLVERR 2'h2

`endif

//--- src/pmx_port0_mux.v
`timescale 1ns/100ps
`include "pmx_defines.vh"

// Contract
// [RQ1] reset leaves pins pulled-up inputs, functions off
// [RQ2] timer0 primary enable drives shared pin
// [RQ3] timer0 counter input from shared pin
// [RQ4] timer0 gate input from shared pin
// [RQ5] strobe input path stays live while driving
// [RQ6] source 100 uses pin level as strobe
// [RQ7] source 101 uses inverted pin level
// [RQ8] chosen edge starts conversion, other acquires
// [RQ9] dual-edge bit picks single or dual
// [RQ10] timer0 secondary enable drives secondary pin
// [RQ11] interrupt 4 blocks timer0 secondary output
// [RQ12] timer1 primary enable drives timer1 pin
// [RQ13] timer1 counter input from timer1 pin
// [RQ14] timer1 gate input from timer1 pin
// [RQ15] interrupt 5 blocks every timer1 function
// [RQ16] pins feed interrupts 3,4,5 when enabled
// [RQ17] special function overrides port direction/output
// [RQ18] interrupt sensing leaves port control untouched
// [RQ19] selection from config, visible next cycle
module pmx_port0_mux #(
  parameter ADDR_W = 8
) (
  input wire aclk, // system clock
  input wire aresetn, // synchronous reset, active low
  input wire [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte enables
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [ADDR_W-1:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire [2:0] pin_in, // pin levels: 0 shared, 1 secondary, 2 timer1
  output reg [2:0] pin_out, // pin output values
  output reg [2:0] pin_oe, // pin output enables
  output reg [2:0] pin_pullup, // weak pullup enables
  input wire timer0_primary_out, // timer 0 primary output
  input wire timer0_secondary_out, // timer 0 secondary output
  input wire timer1_primary_out, // timer 1 primary output
  output reg timer0_count_in, // timer 0 counter input
  output reg timer0_gate_in, // timer 0 gate input
  output reg timer1_count_in, // timer 1 counter input
  output reg timer1_gate_in, // timer 1 gate input
  output reg adc_conversion_strobe, // strobe level to the adc
  output reg adc_start_pulse, // sampling instant, start conversion
  output reg adc_acquire_pulse, // enable adc, begin acquisition
  output reg [2:0] ext_interrupt_in // inputs to interrupts 3, 4, 5
);

  // ****************************************
  // configuration registers
  // ****************************************
  reg [5:0] port_ctrl_reg;
  reg [6:0] timer0_cfg_reg;
  reg [6:0] timer1_cfg_reg;
  reg [4:0] adc_cfg_reg;
  reg [2:0] int_en_reg;

  // write channel holding state
  reg aw_held_reg;
  reg w_held_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg w_strb0_reg;

  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire [7:0] wr_ofs = {aw_addr_reg[7:2], 2'h0};
  wire [7:0] rd_ofs = {s_axi_araddr[7:2], 2'h0};

  // ****************************************
  // pin ownership decode
  // ****************************************
  wire [2:0] dir = port_ctrl_reg[`PMX_PORT_DIR_HI:`PMX_PORT_DIR_LO];
  wire [2:0] pout = port_ctrl_reg[`PMX_PORT_OUT_HI:`PMX_PORT_OUT_LO];
  wire t0_poe = timer0_cfg_reg[`PMX_T_POE];
  wire t0_soe = timer0_cfg_reg[`PMX_T_SOE];
  wire t0_cts = timer0_cfg_reg[`PMX_T_CTS];
  wire [1:0] t0_ccf = timer0_cfg_reg[`PMX_T_CCF_HI:`PMX_T_CCF_LO];
  wire t0_gen = timer0_cfg_reg[`PMX_T_GATE];
  wire t0_cprl = timer0_cfg_reg[`PMX_T_CPRL];
  wire t1_poe = timer1_cfg_reg[`PMX_T_POE];
  wire t1_cts = timer1_cfg_reg[`PMX_T_CTS];
  wire [1:0] t1_ccf = timer1_cfg_reg[`PMX_T_CCF_HI:`PMX_T_CCF_LO];
  wire t1_gen = timer1_cfg_reg[`PMX_T_GATE];
  wire t1_cprl = timer1_cfg_reg[`PMX_T_CPRL];
  wire [2:0] adc_src = adc_cfg_reg[`PMX_ADC_SRC_HI:`PMX_ADC_SRC_LO];
  wire adc_dual = adc_cfg_reg[`PMX_ADC_DUAL];
  wire adc_fall = adc_cfg_reg[`PMX_ADC_EDGE];
  wire ex3 = int_en_reg[`PMX_IE_EX3];
  wire ex4 = int_en_reg[`PMX_IE_EX4];
  wire ex5 = int_en_reg[`PMX_IE_EX5];

  wire t0_cnt_sel = t0_cts & (t0_ccf == `PMX_CCF_NONE) & ~t0_poe; // RQ3
  wire t0_gate_sel = (t0_gen | ((t0_ccf == `PMX_CCF_CAPREL) & t0_cprl))
    & ~t0_poe & ~t0_cts; // RQ4
  wire adc_pin_sel = (adc_src == `PMX_SRC_PIN) | (adc_src == `PMX_SRC_PIN_INV);
  wire t0b_drive = t0_soe & ~ex4; // RQ11
  wire t1_drive = t1_poe & ~ex5; // RQ15
  wire t1_cnt_sel = ~ex5 & t1_cts & (t1_ccf != `PMX_CCF_NONE) & ~t1_poe; // RQ13 RQ15
  wire t1_gate_sel = ~ex5 & (t1_gen | ((t1_ccf == `PMX_CCF_CAPREL) & t1_cprl))
    & ~t1_poe & ~t1_cts; // RQ14 RQ15

  reg [2:0] pin_oe_next;
  reg [2:0] pin_out_next;
  reg strobe_next;

  always @* begin
    // shared pin: a special input owns direction even if port says output
    if (t0_poe) begin
      pin_oe_next[0] = 1'h1; // RQ2
      pin_out_next[0] = timer0_primary_out; // RQ2
    end else if (t0_cnt_sel | t0_gate_sel | adc_pin_sel) begin
      pin_oe_next[0] = 1'h0; // RQ17
      pin_out_next[0] = 1'h0;
    end else begin
      pin_oe_next[0] = dir[0]; // RQ18
      pin_out_next[0] = pout[0];
    end
    if (t0b_drive) begin
      pin_oe_next[1] = 1'h1; // RQ10
      pin_out_next[1] = timer0_secondary_out; // RQ10
    end else begin
      pin_oe_next[1] = dir[1]; // RQ18
      pin_out_next[1] = pout[1];
    end
    if (t1_drive) begin
      pin_oe_next[2] = 1'h1; // RQ12
      pin_out_next[2] = timer1_primary_out; // RQ12
    end else if (t1_cnt_sel | t1_gate_sel) begin
      pin_oe_next[2] = 1'h0; // RQ17
      pin_out_next[2] = 1'h0;
    end else begin
      pin_oe_next[2] = dir[2]; // RQ18
      pin_out_next[2] = pout[2];
    end
    // the pad is read back even while driven, so timer pulses reach the adc
    if (adc_src == `PMX_SRC_PIN) begin
      strobe_next = pin_in[0]; // RQ5 RQ6
    end else if (adc_src == `PMX_SRC_PIN_INV) begin
      strobe_next = ~pin_in[0]; // RQ5 RQ7
    end else begin
      strobe_next = 1'h0;
    end
  end

  // edges come from the pad itself, never from a change of the source field,
  // and the pad history resets to the pulled-up idle level, so choosing a pin
  // source on an idle pin cannot fake a conversion edge
  reg pin0_last_reg;
  wire src_true = (adc_src == `PMX_SRC_PIN);
  wire pin0_rise = pin_in[0] & ~pin0_last_reg;
  wire pin0_fall = ~pin_in[0] & pin0_last_reg;
  wire strobe_rise = adc_pin_sel & (src_true ? pin0_rise : pin0_fall); // RQ6 RQ7
  wire strobe_fall = adc_pin_sel & (src_true ? pin0_fall : pin0_rise); // RQ6 RQ7
  wire start_edge = adc_fall ? strobe_fall : strobe_rise; // RQ8
  wire other_edge = adc_fall ? strobe_rise : strobe_fall; // RQ8

  // ****************************************
  // pin and peripheral outputs
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= 3'h0; // RQ1
      pin_oe <= 3'h0; // RQ1
      pin_pullup <= 3'h7; // RQ1
      timer0_count_in <= 1'h0;
      timer0_gate_in <= 1'h0;
      timer1_count_in <= 1'h0;
      timer1_gate_in <= 1'h0;
      adc_conversion_strobe <= 1'h0;
      adc_start_pulse <= 1'h0;
      adc_acquire_pulse <= 1'h0;
      ext_interrupt_in <= 3'h0;
      pin0_last_reg <= `PMX_RST_PIN_IDLE; // RQ1
    end else begin
      pin_out <= pin_out_next; // RQ19
      pin_oe <= pin_oe_next; // RQ19
      // a pad keeps its weak pullup whenever nothing here drives it
      pin_pullup <= ~pin_oe_next;
      timer0_count_in <= t0_cnt_sel & pin_in[0]; // RQ3
      timer0_gate_in <= t0_gate_sel & pin_in[0]; // RQ4
      timer1_count_in <= t1_cnt_sel & pin_in[2]; // RQ13
      timer1_gate_in <= t1_gate_sel & pin_in[2]; // RQ14
      adc_conversion_strobe <= strobe_next;
      adc_start_pulse <= start_edge; // RQ8
      adc_acquire_pulse <= adc_dual & other_edge; // RQ9
      ext_interrupt_in <= pin_in & {ex5, ex4, ex3}; // RQ16 RQ18
      pin0_last_reg <= pin_in[0];
    end
  end

  // ****************************************
  // axi4-lite write path
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'h0;
      s_axi_wready <= 1'h0;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= `PMX_RESP_OKAY;
      aw_held_reg <= 1'h0;
      w_held_reg <= 1'h0;
      aw_addr_reg <= {ADDR_W{1'h0}};
      w_data_reg <= 32'h0;
      w_strb0_reg <= 1'h0;
      port_ctrl_reg <= `PMX_RST_PORT; // RQ1
      timer0_cfg_reg <= `PMX_RST_TMR; // RQ1
      timer1_cfg_reg <= `PMX_RST_TMR; // RQ1
      adc_cfg_reg <= `PMX_RST_ADC; // RQ1
      int_en_reg <= `PMX_RST_INTEN; // RQ1
    end else begin
      s_axi_awready <= ~aw_held_reg & ~aw_fire & ~s_axi_bvalid;
      s_axi_wready <= ~w_held_reg & ~w_fire & ~s_axi_bvalid;
      if (aw_fire) begin
        aw_held_reg <= 1'h1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_reg <= 1'h1;
        w_data_reg <= s_axi_wdata;
        w_strb0_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_reg <= 1'h0;
        w_held_reg <= 1'h0;
        s_axi_bvalid <= 1'h1;
        s_axi_bresp <= `PMX_RESP_OKAY;
        // every field lives in byte lane 0
        if (wr_ofs == `PMX_OFS_PORT) begin
          if (w_strb0_reg) port_ctrl_reg <= w_data_reg[5:0];
        end else if (wr_ofs == `PMX_OFS_TMR0) begin
          if (w_strb0_reg) timer0_cfg_reg <= w_data_reg[6:0];
        end else if (wr_ofs == `PMX_OFS_TMR1) begin
          if (w_strb0_reg) timer1_cfg_reg <= w_data_reg[6:0];
        end else if (wr_ofs == `PMX_OFS_ADC) begin
          if (w_strb0_reg) adc_cfg_reg <= w_data_reg[4:0];
        end else if (wr_ofs == `PMX_OFS_INTEN) begin
          if (w_strb0_reg) int_en_reg <= w_data_reg[2:0];
        end else if (wr_ofs == `PMX_OFS_STATUS) begin
          s_axi_bresp <= `PMX_RESP_OKAY;
        end else begin
          s_axi_bresp <= `PMX_RESP_SLVERR;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'h0;
      end
    end
  end

  // ****************************************
  // axi4-lite read path
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `PMX_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_fire;
      if (ar_fire) begin
        s_axi_rvalid <= 1'h1;
        s_axi_rresp <= `PMX_RESP_OKAY;
        if (rd_ofs == `PMX_OFS_PORT) begin
          s_axi_rdata <= {26'h0, port_ctrl_reg};
        end else if (rd_ofs == `PMX_OFS_TMR0) begin
          s_axi_rdata <= {25'h0, timer0_cfg_reg};
        end else if (rd_ofs == `PMX_OFS_TMR1) begin
          s_axi_rdata <= {25'h0, timer1_cfg_reg};
        end else if (rd_ofs == `PMX_OFS_ADC) begin
          s_axi_rdata <= {27'h0, adc_cfg_reg};
        end else if (rd_ofs == `PMX_OFS_INTEN) begin
          s_axi_rdata <= {29'h0, int_en_reg};
        end else if (rd_ofs == `PMX_OFS_STATUS) begin
          s_axi_rdata <= {25'h0, adc_conversion_strobe, pin_oe, pin_in};
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `PMX_RESP_SLVERR;
        end
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'h0;
      end
    end
  end

endmodule // pmx_port0_mux

//--- verification/pmx_port0_mux_props.sv
`timescale 1ns/100ps
// ****
// pin mux checker
// ****
module pmx_port0_mux_props (
  input wire aclk, // clock
  input wire aresetn, // reset, low
  input wire [2:0] pin_in, // pad levels
  input wire [2:0] pin_oe, // pad drive
  input wire [2:0] pin_pullup, // pullups
  input wire timer0_count_in, // t0 count
  input wire timer0_gate_in, // t0 gate
  input wire timer1_count_in, // t1 count
  input wire timer1_gate_in, // t1 gate
  input wire adc_conversion_strobe, // strobe
  input wire adc_start_pulse, // start
  input wire adc_acquire_pulse, // acquire
  input wire [2:0] ext_interrupt_in // interrupts
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RST: assert property ($rose(aresetn) |-> pin_oe == 3'h0 && pin_pullup == 3'h7)
    else $error("pins not idle after reset");
  AST_PULL: assert property (pin_pullup == ~pin_oe)
    else $error("pullup not opposite of drive");
  AST_INT: assert property ((ext_interrupt_in & ~$past(pin_in)) == 3'h0)
    else $error("interrupt input without pin high");
  AST_T0IN: assert property ((timer0_count_in | timer0_gate_in) |-> $past(pin_in[0]) && !pin_oe[0])
    else $error("timer0 input not from idle pin");
  AST_T1IN: assert property ((timer1_count_in | timer1_gate_in) |-> $past(pin_in[2]) && !pin_oe[2])
    else $error("timer1 input not from idle pin");
  AST_T0EX: assert property (!(timer0_count_in && timer0_gate_in))
    else $error("timer0 count and gate together");
  AST_T1EX: assert property (!(timer1_count_in && timer1_gate_in))
    else $error("timer1 count and gate together");
  AST_EDGE: assert property ((adc_start_pulse | adc_acquire_pulse) |->
    $past(pin_in[0]) != $past(pin_in[0], 2))
    else $error("adc pulse without pad edge");
  AST_PAIR: assert property (!(adc_start_pulse && adc_acquire_pulse))
    else $error("start and acquire together");
endmodule // pmx_port0_mux_props

bind pmx_port0_mux pmx_port0_mux_props pmx_port0_mux_props_i (.*);

//--- verification/pmx_pad_model.sv
`timescale 1ns/100ps
// ****
// pads and outside circuitry
// ****
module pmx_pad_model (
  input logic [2:0] pin_out, // device value
  input logic [2:0] pin_oe, // device drives
  input logic [2:0] pin_pullup, // weak pullup
  input logic [2:0] ext_drv, // outside value
  input logic [2:0] ext_en, // outside drives
  output logic [2:0] pin_in // resolved level
);
  // no keeper on the pad: undriven without pullup shows the inverse of pin_out
  always_comb
    for (int i = 0; i < 3; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_drv[i] :
        pin_pullup[i] ? 1'b1 : ~pin_out[i];
endmodule // pmx_pad_model

//--- verification/testbench.sv
`timescale 1ns/100ps
`include "pmx_defines.vh"
module testbench;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, timer0_count_in, timer0_gate_in, timer1_count_in;
  logic timer1_gate_in, adc_conversion_strobe, adc_start_pulse, adc_acquire_pulse;
  logic timer0_primary_out = 0, timer0_secondary_out = 0, timer1_primary_out = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, kind = 0;
  logic [2:0] pin_in, pin_out, pin_oe, pin_pullup, ext_interrupt_in, ext_drv = 0, ext_en = 0;
  logic [7:0] cfg [5] = '{8'h04, 8'h0C, 8'h24, 8'h58, 8'h20};
  logic [3:0] tin [5] = '{4'h8, 4'h2, 4'h8, 4'h5, 4'h5};
  logic [33:0] q [$];
  logic [31:0] v;
  int fails = 0, num_checks = 0, seed = 65, sc = 0, ac = 0, i, j;
  wire [13:0] obs = {pin_oe, pin_out & pin_oe, timer0_count_in, timer0_gate_in,
    timer1_count_in, timer1_gate_in, adc_conversion_strobe, ext_interrupt_in};
  pmx_port0_mux pmx_port0_mux_i (.*);
  pmx_pad_model pmx_pad_model_i (.*);
  initial forever #12.5 aclk = ~aclk;
  // ****
  // bus and sampling tasks
  // ****
  task wr(input [7:0] a, input [7:0] d, input [1:0] r);
    logic pa, pw;
    begin
      q.push_back({32'h0, r});
      pa = 1;
      pw = 1;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (pa | pw) begin
        @(posedge aclk);
        if (pa && s_axi_awready) begin
          s_axi_awvalid <= 0;
          pa = 0;
        end
        if (pw && s_axi_wready) begin
          s_axi_wvalid <= 0;
          pw = 0;
        end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
      @(posedge aclk);
    end
  endtask
  task rd(input [7:0] a, input [33:0] e);
    begin
      q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 0;
      @(posedge aclk);
    end
  endtask
  task smp(input [33:0] e, input [1:0] k);
    begin
      repeat (4) @(posedge aclk);
      q.push_back(e);
      kind <= k;
      @(posedge aclk);
      kind <= 0;
    end
  endtask
  task cmp(input string n, input [33:0] g);
    logic [33:0] e;
    begin
      e = q.pop_front();
      num_checks++;
      if (e !== g) begin
        fails++;
        $display("BAD %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // results are compared in order of appearance
  always @(posedge aclk) begin
    if (adc_start_pulse) sc++;
    if (adc_acquire_pulse) ac++;
    if (s_axi_bvalid && s_axi_bready) cmp("bresp", {32'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready) cmp("read", {s_axi_rresp, s_axi_rdata});
    if (kind == 1) cmp("pins", {20'h0, obs});
    if (kind == 2) cmp("pulses", {18'h0, sc[7:0], ac[7:0]});
  end
  initial begin
    repeat (6000) @(posedge aclk);
    fails++;
    stop_test;
  end
  // ****
  // scenarios
  // ****
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    smp(34'h0, 1);
    for (i = 0; i < 5; i++) rd(i * 4, 34'h0);
    rd(8'h14, 34'h7);
    rd(8'h18, {2'h2, 32'h0});
    wr(8'h18, 8'h01, 2'h2);
    wr(8'h14, 8'hFF, 2'h0);
    s_axi_wstrb <= 4'hE;
    wr(8'h00, 8'h3F, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(8'h00, 34'h0);
    wr(8'h10, 8'h07, 2'h0);
    ext_en <= 3'h7;
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      ext_drv <= v[2:0];
      smp({31'h0, v[2:0]}, 1);
    end
    wr(8'h10, 8'h00, 2'h0);
    ext_drv <= 3'h5;
    for (i = 0; i < 5; i++) begin
      wr(8'h04, cfg[i], 2'h0);
      wr(8'h08, cfg[i], 2'h0);
      smp({26'h0, tin[i], 4'h0}, 1);
    end
    wr(8'h10, 8'h04, 2'h0);
    smp(34'b000_000_0100_0_100, 1);
    ext_en <= 3'h1;
    timer1_primary_out <= 1;
    wr(8'h08, 8'h01, 2'h0);
    smp(34'b000_000_0100_0_100, 1);
    wr(8'h10, 8'h00, 2'h0);
    smp(34'b100_100_0100_0_000, 1);
    ext_en <= 3'h0;
    timer0_secondary_out <= 1;
    wr(8'h04, 8'h02, 2'h0);
    smp(34'b110_110_0000_0_000, 1);
    wr(8'h10, 8'h02, 2'h0);
    smp(34'b100_100_0000_0_010, 1);
    wr(8'h00, 8'h17, 2'h0);
    smp(34'b111_110_0000_0_010, 1);
    wr(8'h00, 8'h00, 2'h0);
    wr(8'h10, 8'h00, 2'h0);
    wr(8'h04, 8'h01, 2'h0);
    wr(8'h0C, 8'h04, 2'h0);
    smp(34'b101_100_0000_0_000, 1);
    timer0_primary_out <= 1;
    smp(34'b101_101_0000_1_000, 1);
    timer0_primary_out <= 0;
    wr(8'h0C, 8'h00, 2'h0);
    wr(8'h04, 8'h00, 2'h0);
    ext_en <= 3'h1;
    ext_drv <= 3'h1;
    wr(8'h0C, 8'h05, 2'h0);
    smp(34'b100_100_0000_0_000, 1);
    ext_drv <= 3'h0;
    smp(34'b100_100_0000_1_000, 1);
    ext_drv <= 3'h1;
    repeat (3) @(posedge aclk);
    // the pad toggles after each mode write; it starts high in the first mode
    for (j = 0; j < 3; j++) begin
      wr(8'h0C, j == 0 ? 8'h04 : j == 1 ? 8'h0C : 8'h1C, 2'h0);
      for (i = 0; i < 6; i++) begin
        ext_drv <= {2'h0, ~i[0]};
        repeat (3) @(posedge aclk);
      end
    end
    smp({18'h0, 8'd10, 8'd6}, 2);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    smp(34'h0, 1);
    stop_test;
  end
endmodule // testbench
